/* File: src/pmmc_map.svh */
// Constants for the monitor mode control registers
`ifndef PMMC_MAP_SVH
`define PMMC_MAP_SVH

// Special register numbers
`define PMMC_SPR_W 10
`define PMMC_SPR_CTL0 10'h3B8
`define PMMC_SPR_MIR0 10'h3A8
`define PMMC_SPR_CTL1 10'h3BC
`define PMMC_SPR_MIR1 10'h3AC

// Reset values
`define PMMC_CTL0_RST 32'h0000_0000
`define PMMC_CTL1_RST 32'h0000_0000

// Control zero fields, little-endian bit index (big-endian n is 31-n)
`define PMMC_C0_FREEZE 31
`define PMMC_C0_EXC_EN 26
`define PMMC_C0_FRZ_EVT 25
`define PMMC_C0_TB_EN 22
`define PMMC_C0_C1_NEG_EN 15
`define PMMC_C0_CJ_NEG_EN 14
`define PMMC_C0_HOLD 13
`define PMMC_C0_SEL1_HI 12
`define PMMC_C0_SEL1_LO 6
`define PMMC_C0_SEL2_HI 5
`define PMMC_C0_SEL2_LO 0

// Control one fields and writable mask
`define PMMC_C1_SEL3_HI 31
`define PMMC_C1_SEL3_LO 27
`define PMMC_C1_SEL4_HI 26
`define PMMC_C1_SEL4_LO 22
`define PMMC_C1_MASK 32'hFFC0_0000

`endif

/* File: src/pmmc_pkg.sv */
// Types for the monitor mode control registers
package pmmc_pkg;

    // Event selector widths
    typedef logic [6:0] pmmc_sel7_t;
    typedef logic [5:0] pmmc_sel6_t;
    typedef logic [4:0] pmmc_sel5_t;

    // Decoded special register target, one-hot
    typedef enum logic [4:0] {
        PMMC_TGT_NONE = 5'h01,
        PMMC_TGT_CTL0 = 5'h02,
        PMMC_TGT_CTL1 = 5'h04,
        PMMC_TGT_MIR0 = 5'h08,
        PMMC_TGT_MIR1 = 5'h10
    } pmmc_tgt_e;

endpackage : pmmc_pkg

/* File: src/pmmc_mode_ctrl.sv */
// Performance monitor mode control registers, hold and event selectors
`timescale 1ns/1ps
`include "pmmc_map.svh"

module pmmc_mode_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Special register move port
    input wire logic [9:0] spr_num_in,
    input wire logic spr_wr_in,
    input wire logic spr_rd_in,
    input wire logic spr_user_in,
    input wire logic [31:0] spr_wdata_in,
    output logic [31:0] spr_rdata_out,
    output logic spr_ack_out,
    output logic spr_fault_out,
    // Conditions from the counters and time base
    input wire logic first_counter_negative_in,
    input wire logic other_counter_negative_in,
    input wire logic time_base_event_in,
    input wire logic enabled_event_in,
    // Control towards the counters
    output logic [31:0] monitor_control_zero_out,
    output logic first_counter_run_out,
    output logic other_counters_run_out,
    output logic other_counters_hold_out,
    output logic enabled_condition_out,
    output pmmc_pkg::pmmc_sel7_t first_counter_event_select_out,
    output pmmc_pkg::pmmc_sel6_t second_counter_event_select_out,
    output pmmc_pkg::pmmc_sel5_t third_counter_event_select_out,
    output pmmc_pkg::pmmc_sel5_t fourth_counter_event_select_out
);

    // Reset synchroniser stages
    logic rst_meta_reg;
    logic rst_sync_n_reg;

    // Register state
    logic [31:0] monitor_control_zero_reg;
    logic [31:0] monitor_control_zero_next;
    logic [31:0] monitor_control_one_reg;
    logic [31:0] monitor_control_one_next;

    // Read port state
    logic [31:0] rdata_reg;
    logic ack_reg;
    logic fault_reg;

    // Registered counter run controls
    logic first_run_reg;
    logic other_run_reg;
    logic cond_reg;

    // Decode and event terms
    pmmc_pkg::pmmc_tgt_e tgt;
    logic wr_ctl0;
    logic wr_ctl1;
    logic rd_ok;
    logic acc_fault;
    logic cond_seen;
    logic release_hold;
    logic freeze_hit;
    logic hold_now;

    // Map a special register number to its target
    function automatic pmmc_pkg::pmmc_tgt_e spr_decode(input logic [9:0] num);
        pmmc_pkg::pmmc_tgt_e t;
        t = pmmc_pkg::PMMC_TGT_NONE;
        if (num == `PMMC_SPR_CTL0) begin
            t = pmmc_pkg::PMMC_TGT_CTL0;
        end else if (num == `PMMC_SPR_CTL1) begin
            t = pmmc_pkg::PMMC_TGT_CTL1;
        end else if (num == `PMMC_SPR_MIR0) begin
            t = pmmc_pkg::PMMC_TGT_MIR0;
        end else if (num == `PMMC_SPR_MIR1) begin
            t = pmmc_pkg::PMMC_TGT_MIR1;
        end
        return t;
    endfunction : spr_decode

    // Release reset through two flops
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    assign tgt = spr_decode(spr_num_in);
    assign hold_now = monitor_control_zero_reg[`PMMC_C0_HOLD];

    // Access rights: mirrors are read-only, privileged ones need supervisor
    always_comb begin
        wr_ctl0 = 1'b0;
        wr_ctl1 = 1'b0;
        rd_ok = 1'b0;
        acc_fault = 1'b0;
        unique case (tgt)
            pmmc_pkg::PMMC_TGT_CTL0: begin
                wr_ctl0 = spr_wr_in && !spr_user_in;
                rd_ok = spr_rd_in && !spr_user_in;
                acc_fault = (spr_wr_in || spr_rd_in) && spr_user_in;
            end
            pmmc_pkg::PMMC_TGT_CTL1: begin
                wr_ctl1 = spr_wr_in && !spr_user_in;
                rd_ok = spr_rd_in && !spr_user_in;
                acc_fault = (spr_wr_in || spr_rd_in) && spr_user_in;
            end
            pmmc_pkg::PMMC_TGT_MIR0: begin
                rd_ok = spr_rd_in;
                acc_fault = spr_wr_in;
            end
            pmmc_pkg::PMMC_TGT_MIR1: begin
                rd_ok = spr_rd_in;
                acc_fault = spr_wr_in;
            end
            pmmc_pkg::PMMC_TGT_NONE: begin
                acc_fault = spr_wr_in || spr_rd_in;
            end
        endcase
    end

    // Enabled conditions and events seen this cycle
    always_comb begin
        cond_seen = enabled_event_in;
        if (monitor_control_zero_reg[`PMMC_C0_C1_NEG_EN] && first_counter_negative_in) begin
            cond_seen = 1'b1;
        end
        if (monitor_control_zero_reg[`PMMC_C0_CJ_NEG_EN] && other_counter_negative_in) begin
            cond_seen = 1'b1;
        end
        if (monitor_control_zero_reg[`PMMC_C0_TB_EN] && time_base_event_in) begin
            cond_seen = 1'b1;
        end
    end

    // Hold ends on first counter negative or any enabled condition
    assign release_hold = hold_now && (first_counter_negative_in || cond_seen);
    // Freeze-on-event acts only while the hold is clear
    assign freeze_hit = cond_seen && !hold_now
        && monitor_control_zero_reg[`PMMC_C0_FRZ_EVT];

    // Next value of control zero; hardware freeze wins over a write
    always_comb begin
        monitor_control_zero_next = monitor_control_zero_reg;
        if (wr_ctl0) begin
            monitor_control_zero_next = spr_wdata_in;
        end else if (release_hold) begin
            monitor_control_zero_next[`PMMC_C0_HOLD] = 1'b0;
        end
        if (freeze_hit) begin
            monitor_control_zero_next[`PMMC_C0_FREEZE] = 1'b1;
        end
    end

    // Control zero storage
    always_ff @(posedge clk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            monitor_control_zero_reg <= `PMMC_CTL0_RST;
        end else begin
            monitor_control_zero_reg <= monitor_control_zero_next;
        end
    end

    // Control one keeps only its two selectors
    always_comb begin
        monitor_control_one_next = monitor_control_one_reg;
        if (wr_ctl1) begin
            monitor_control_one_next = spr_wdata_in & `PMMC_C1_MASK;
        end
    end

    // Control one storage
    always_ff @(posedge clk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            monitor_control_one_reg <= `PMMC_CTL1_RST;
        end else begin
            monitor_control_one_reg <= monitor_control_one_next;
        end
    end

    // Read answer one cycle after the request; faults read zero
    always_ff @(posedge clk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            ack_reg <= spr_wr_in || spr_rd_in;
            fault_reg <= acc_fault;
            rdata_reg <= 32'h0000_0000;
            if (rd_ok) begin
                unique case (tgt)
                    pmmc_pkg::PMMC_TGT_CTL0: rdata_reg <= monitor_control_zero_reg;
                    pmmc_pkg::PMMC_TGT_MIR0: rdata_reg <= monitor_control_zero_reg;
                    pmmc_pkg::PMMC_TGT_CTL1: rdata_reg <= monitor_control_one_reg;
                    pmmc_pkg::PMMC_TGT_MIR1: rdata_reg <= monitor_control_one_reg;
                    pmmc_pkg::PMMC_TGT_NONE: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Counter run controls follow the next register state, so they
    // line up with the control bits seen on the outputs
    always_ff @(posedge clk_in or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            first_run_reg <= 1'b0;
            other_run_reg <= 1'b0;
            cond_reg <= 1'b0;
        end else begin
            first_run_reg <= !monitor_control_zero_next[`PMMC_C0_FREEZE];
            other_run_reg <= !monitor_control_zero_next[`PMMC_C0_FREEZE]
                && !monitor_control_zero_next[`PMMC_C0_HOLD];
            cond_reg <= cond_seen;
        end
    end

    // Outputs, all straight from flops
    assign spr_rdata_out = rdata_reg;
    assign spr_ack_out = ack_reg;
    assign spr_fault_out = fault_reg;
    assign monitor_control_zero_out = monitor_control_zero_reg;
    assign first_counter_run_out = first_run_reg;
    assign other_counters_run_out = other_run_reg;
    assign other_counters_hold_out = monitor_control_zero_reg[`PMMC_C0_HOLD];
    assign enabled_condition_out = cond_reg;
    assign first_counter_event_select_out =
        monitor_control_zero_reg[`PMMC_C0_SEL1_HI:`PMMC_C0_SEL1_LO];
    assign second_counter_event_select_out =
        monitor_control_zero_reg[`PMMC_C0_SEL2_HI:`PMMC_C0_SEL2_LO];
    assign third_counter_event_select_out =
        monitor_control_one_reg[`PMMC_C1_SEL3_HI:`PMMC_C1_SEL3_LO];
    assign fourth_counter_event_select_out =
        monitor_control_one_reg[`PMMC_C1_SEL4_HI:`PMMC_C1_SEL4_LO];

endmodule : pmmc_mode_ctrl

/* File: tb/pmmc_mode_ctrl_chk.sv */
// Assertion checker for the monitor mode control registers
`timescale 1ns/1ps
module pmmc_mode_ctrl_chk (
    // Clock, reset and register port
    input logic clk_in, reset_n_in, spr_wr_in, spr_rd_in, spr_user_in, spr_ack_out, spr_fault_out,
    input logic [9:0] spr_num_in,
    input logic [31:0] spr_wdata_in, monitor_control_zero_out,
    // Conditions and counter control
    input logic first_counter_negative_in, other_counter_negative_in, time_base_event_in, enabled_event_in,
    input logic other_counters_run_out, other_counters_hold_out, enabled_condition_out,
    input pmmc_pkg::pmmc_sel7_t first_counter_event_select_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // No condition input active, so hardware cannot contend with a write
    sequence quiet;
        !(first_counter_negative_in || other_counter_negative_in || time_base_event_in || enabled_event_in);
    endsequence
    // Hold armed, release cause seen, no write racing it
    sequence hold_trip;
        other_counters_hold_out && !spr_wr_in && !monitor_control_zero_out[31]
            && (first_counter_negative_in || enabled_event_in);
    endsequence
    // Privileged move to control zero
    sequence ctl0_write;
        spr_wr_in && !spr_user_in && spr_num_in == 10'h3B8;
    endsequence

    ack_timing_a: assert property ((spr_wr_in || spr_rd_in) |=> spr_ack_out)
        else $error("ack missing after strobe");
    fault_ack_a: assert property (spr_fault_out |-> spr_ack_out)
        else $error("fault without ack");
    user_write_fault_a: assert property (spr_wr_in && spr_user_in |=> spr_fault_out)
        else $error("user write not refused");
    hold_release_a: assert property (hold_trip |=> !other_counters_hold_out && other_counters_run_out)
        else $error("hold not released");
    hold_blocks_a: assert property (other_counters_hold_out |-> !other_counters_run_out)
        else $error("other counters run while held");
    sel_map_a: assert property (first_counter_event_select_out == monitor_control_zero_out[12:6])
        else $error("first select differs from field");
    ctl0_write_a: assert property ((ctl0_write and quiet)
        |=> monitor_control_zero_out == $past(spr_wdata_in)) else $error("control zero write lost");
    sel_write_a: assert property ((ctl0_write and quiet) |=>
        first_counter_event_select_out == $past(spr_wdata_in[12:6])) else $error("first select not written");
    cond_delay_a: assert property (enabled_event_in |=> enabled_condition_out)
        else $error("enabled event not reported");
    freeze_ignore_a: assert property (monitor_control_zero_out[13] && !monitor_control_zero_out[31]
        && !spr_wr_in |=> !monitor_control_zero_out[31]) else $error("freeze set while held");
endmodule : pmmc_mode_ctrl_chk

bind pmmc_mode_ctrl pmmc_mode_ctrl_chk chk (.*);

/* File: tb/pmmc_mode_ctrl_tb.sv */
// Self-checking bench for the monitor mode control registers
`timescale 1ns/1ps
module pmmc_mode_ctrl_tb;
    logic clk_in, reset_n_in, spr_wr_in, spr_rd_in, spr_user_in, spr_ack_out, spr_fault_out;
    logic first_counter_run_out, other_counters_run_out, other_counters_hold_out, enabled_condition_out;
    logic [9:0] spr_num_in;
    logic [31:0] spr_wdata_in, spr_rdata_out, monitor_control_zero_out, w0, w1;
    logic [3:0] cnd;
    pmmc_pkg::pmmc_sel7_t first_counter_event_select_out;
    pmmc_pkg::pmmc_sel6_t second_counter_event_select_out;
    pmmc_pkg::pmmc_sel5_t third_counter_event_select_out, fourth_counter_event_select_out;
    integer seed = 32'h482f;
    int mismatches = 0;
    int n_compared = 0;

    pmmc_mode_ctrl uut (.*, .first_counter_negative_in(cnd[3]), .other_counter_negative_in(cnd[2]),
        .time_base_event_in(cnd[1]), .enabled_event_in(cnd[0]));

    // Free-running 200 MHz clock
    initial begin
        clk_in = 0;
        forever #2.5 clk_in = ~clk_in;
    end

    // Reserved lower part of control one reads zero
    function logic [31:0] mir1(input logic [31:0] w);
        return w & 32'hFFC0_0000;
    endfunction : mir1

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One move access; answer looked at in its single ack cycle
    task acc(input logic wr, input logic usr, input logic [9:0] n, input logic [31:0] d, input logic flt,
        input logic [31:0] e);
        @(posedge clk_in);
        spr_wr_in <= wr;
        spr_rd_in <= !wr;
        spr_user_in <= usr;
        spr_num_in <= n;
        spr_wdata_in <= d;
        @(posedge clk_in);
        spr_wr_in <= 0;
        spr_rd_in <= 0;
        #1;
        chk("ack", 1, spr_ack_out);
        chk("fault", flt, spr_fault_out);
        chk("rdata", e, spr_rdata_out);
    endtask : acc

    // One-cycle pulse on the condition inputs
    task cond(input logic [3:0] v);
        @(posedge clk_in);
        cnd <= v;
        @(posedge clk_in);
        cnd <= 0;
        #1;
    endtask : cond

    task complete_run;
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // Watchdog well beyond the expected run length
    initial begin
        #20000;
        mismatches++;
        complete_run();
    end

    initial begin
        reset_n_in = 0;
        {spr_wr_in, spr_rd_in, spr_user_in, spr_num_in, spr_wdata_in, cnd} = 0;
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1;
        repeat (3) @(posedge clk_in);
        #1;
        chk("runj", 1, other_counters_run_out);
        acc(0, 0, 10'h3B8, 0, 0, 0);
        acc(0, 0, 10'h3BC, 0, 0, 0);
        // All-ones corner first, then random words; refused accesses must leave state alone
        for (int i = 0; i < 20; i++) begin
            w0 = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            w1 = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            acc(1, 0, 10'h3B8, w0, 0, 0);
            acc(1, 0, 10'h3BC, w1, 0, 0);
            acc(0, 0, 10'h3B8, 0, 0, w0);
            acc(0, 1, 10'h3A8, 0, 0, w0);
            acc(0, 0, 10'h3BC, 0, 0, mir1(w1));
            acc(0, 1, 10'h3AC, 0, 0, mir1(w1));
            acc(0, 1, 10'h3BC, 0, 1, 0);
            acc(1, 1, 10'h3B8, ~w0, 1, 0);
            acc(1, 0, 10'h3A8, ~w0, 1, 0);
            acc(1, 0, 10'h3B9, ~w1, 1, 0);
            acc(0, 1, 10'h3B8, 0, 1, 0);
            acc(1, 1, 10'h3BC, ~w1, 1, 0);
            acc(1, 0, 10'h3AC, ~w1, 1, 0);
            chk("ctl0", w0, monitor_control_zero_out);
            chk("sel1", w0[12:6], first_counter_event_select_out);
            chk("sel2", w0[5:0], second_counter_event_select_out);
            chk("sel3", w1[31:27], third_counter_event_select_out);
            chk("sel4", w1[26:22], fourth_counter_event_select_out);
        end
        // Capture between negatives: hold, first released, then frozen by another counter
        acc(1, 0, 10'h3B8, 32'h0200_6000, 0, 0);
        chk("runj", 0, other_counters_run_out);
        chk("run1", 1, first_counter_run_out);
        cond(4'b1000);
        chk("hold", 0, other_counters_hold_out);
        chk("runj", 1, other_counters_run_out);
        chk("ctl0", 32'h0200_4000, monitor_control_zero_out);
        cond(4'b0100);
        chk("ctl0", 32'h8200_4000, monitor_control_zero_out);
        chk("run1", 0, first_counter_run_out);
        chk("cond", 1, enabled_condition_out);
        // Release by another enabled event, then frozen by a second one
        acc(1, 0, 10'h3B8, 32'h0200_2000, 0, 0);
        cond(4'b0001);
        chk("hold", 0, other_counters_hold_out);
        chk("ctl0", 32'h0200_0000, monitor_control_zero_out);
        chk("cond", 1, enabled_condition_out);
        cond(4'b0001);
        chk("ctl0", 32'h8200_0000, monitor_control_zero_out);
        // Disabled other-counter negative and time base leave the hold armed
        acc(1, 0, 10'h3B8, 32'h0000_2000, 0, 0);
        cond(4'b0110);
        chk("hold", 1, other_counters_hold_out);
        chk("cond", 0, enabled_condition_out);
        acc(1, 0, 10'h3B8, 32'h0040_2000, 0, 0);
        cond(4'b0010);
        chk("ctl0", 32'h0040_0000, monitor_control_zero_out);
        acc(1, 0, 10'h3B8, 0, 0, 0);
        chk("run1", 1, first_counter_run_out);
        chk("runj", 1, other_counters_run_out);
        // Mid-run reset clears both registers and the run controls
        acc(1, 0, 10'h3B8, 32'h0000_1FFF, 0, 0);
        acc(1, 0, 10'h3BC, 32'hFFFF_FFFF, 0, 0);
        @(posedge clk_in);
        reset_n_in <= 0;
        #1;
        chk("ctl0", 0, monitor_control_zero_out);
        chk("sel3", 0, third_counter_event_select_out);
        chk("run1", 0, first_counter_run_out);
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1;
        repeat (3) @(posedge clk_in);
        #1;
        chk("runj", 1, other_counters_run_out);
        acc(0, 0, 10'h3BC, 0, 0, 0);
        complete_run();
    end
endmodule : pmmc_mode_ctrl_tb
